// *** pkg/pmfc_pkg.sv ***
// Overview of operation
// R01 - bit 4 routes traffic around async FIFO
// R02 - bit 3 delays receive clock at 10/100
// R03 - bit 2 selects low-latency 10/100 datapath
// R04 - bit 1 is receive threshold top bit
// R05 - bit 0 is transmit threshold top bit
// R06 - eight-deep FIFOs, threshold 2 starts at 4
// R07 - each threshold step adds one read cycle
// R08 - status bit 1 shows new page received
// R09 - status bit 0 shows negotiation finished
// R10 - errored bytes counted, single mode saturates 0xFF
// R11 - writing bit 7 freezes checker counters
// R12 - writing bit 8 freezes and clears counters
// R13 - sync loss latched high until read
// R14 - bit 4 shows checker locked
// R15 - bit 2 set on byte counter overflow
// R16 - bit 1 selects continuous or single counting
// R17 - bit 0 enables transmit-path pattern checker
// R18 - total byte count, single mode saturates 0xFFFF
// R19 - continuous mode wraps, wrap sets overflow
package pmfc_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_THR_LOW   = 6'h32; // lower threshold bits
  localparam logic [5:0] IDX_FIFO_CTRL = 6'h33; // fifo latency control
  localparam logic [5:0] IDX_NEG_STAT  = 6'h37; // serial mac negotiation status
  localparam logic [5:0] IDX_CHK_CTRL  = 6'h39; // pattern checker control
  localparam logic [5:0] IDX_CHK_BYTES = 6'h3A; // pattern checker byte count
  localparam logic [5:0] IDX_IRQ_STAT  = 6'h3C; // sticky event status
  localparam logic [5:0] IDX_IRQ_MASK  = 6'h3D; // event mask
  // fifo latency control fields
  localparam int B_SKIP_EN    = 4;
  localparam int B_SKIP_DLY   = 3;
  localparam int B_LOW_LAT    = 2;
  localparam int B_RX_THR_TOP = 1;
  localparam int B_TX_THR_TOP = 0;
  // lower threshold fields
  localparam int B_RX_LOW_HI = 6;
  localparam int B_RX_LOW_LO = 5;
  localparam int B_TX_LOW_HI = 4;
  localparam int B_TX_LOW_LO = 3;
  localparam logic [1:0] THR_LOW_RST = 2'h2; // default threshold low bits
  localparam logic [3:0] THR_GAP_OFS = 4'h2; // pointer gap minus threshold
  localparam int FIFO_DEPTH = 8;             // sync fifo entries
  // negotiation status fields
  localparam int B_PAGE_RX  = 1;
  localparam int B_NEG_DONE = 0;
  // checker control fields
  localparam int B_ERR_HI    = 14;
  localparam int B_ERR_LO    = 7;
  localparam int B_FREEZE    = 7;
  localparam int B_CLEAR     = 8;
  localparam int B_SYNC_LOST = 5;
  localparam int B_LOCKED    = 4;
  localparam int B_BYTE_OVF  = 2;
  localparam int B_CNT_MODE  = 1;
  localparam int B_CHK_EN    = 0;
  // interrupt event bits
  localparam int IRQ_W        = 4;
  localparam int E_SYNC_LOST  = 0;
  localparam int E_BYTE_OVF   = 1;
  localparam int E_PAGE_RX    = 2;
  localparam int E_NEG_DONE   = 3;
  localparam logic [15:0] REG_RST = 16'h0000; // common register reset

  // checker datapath events into the register bank
  typedef struct packed {
    logic byte_valid; // one byte compared this cycle
    logic byte_error; // that byte mismatched
    logic locked;     // checker locked on stream
    logic sync_loss;  // one-cycle loss of sync
  } pmfc_chk_evt_t;

  // fifo path controls out of the register bank
  typedef struct packed {
    logic       skip_enable;   // bypass async fifo
    logic       rxclk_delay;   // delay rx clock now
    logic       low_latency;   // low latency path now
    logic [2:0] rx_threshold;  // rx half-full threshold
    logic [2:0] tx_threshold;  // tx half-full threshold
    logic [3:0] rx_start_gap;  // rx pointer lead to start reading
    logic [3:0] tx_start_gap;  // tx pointer lead to start reading
  } pmfc_fifo_ctl_t;
endpackage

// *** hw/pmfc_regs.sv ***
module pmfc_regs
  import pmfc_pkg::*;
#(
  parameter int ERR_W  = 8,  // errored byte counter width
  parameter int BYTE_W = 16  // total byte counter width
) (
  input  wire logic           core_clk,      // 40 MHz core clock
  input  wire logic           reset_n,       // synchronous reset, low active
  input  wire logic           ce,            // clock enable, low freezes all
  input  wire logic           psel,          // apb select
  input  wire logic           penable,       // apb access phase
  input  wire logic           pwrite,        // apb write
  input  wire logic [7:0]     paddr,         // apb byte address
  input  wire logic [31:0]    pwdata,        // apb write data
  output logic      [31:0]    prdata,        // apb read data
  output logic                pready,        // apb ready
  output logic                pslverr,       // apb error on unmapped
  input  wire logic           speed_10_100,  // link runs at 10 or 100 Mbps
  input  wire logic           neg_page_rx,   // serial mac page received
  input  wire logic           serial_neg_done, // serial mac negotiation done
  input  wire pmfc_chk_evt_t  chk_evt,       // checker datapath events
  output pmfc_fifo_ctl_t      fifo_ctl,      // fifo path controls
  output logic                checker_enable, // checker on
  output logic                checker_count_mode, // 1 continuous
  output logic                irq            // level interrupt
);

  // register state
  logic [1:0]        rx_low_q;      // rx threshold low bits
  logic [1:0]        tx_low_q;      // tx threshold low bits
  logic [4:0]        fifo_ctrl_q;   // fifo latency control bits
  logic              chk_en_q;      // checker enable
  logic              cnt_mode_q;    // counting mode
  logic              frozen_q;      // counters frozen
  logic              sync_lost_q;   // latched sync loss
  logic              byte_ovf_q;    // byte counter overflow
  logic [ERR_W-1:0]  err_cnt_q;     // errored bytes
  logic [BYTE_W-1:0] byte_cnt_q;    // total bytes
  logic [IRQ_W-1:0]  irq_stat_q;    // sticky events
  logic [IRQ_W-1:0]  irq_mask_q;    // event mask
  logic              neg_done_q;    // negotiation done, last cycle
  pmfc_fifo_ctl_t    fifo_ctl_q;    // registered fifo controls
  logic [31:0]       prdata_q;      // read data
  logic              pready_q;      // ready
  logic              pslverr_q;     // error
  logic              irq_q;         // interrupt

  // bus decode
  logic [5:0]        idx;           // word index of access
  logic              done;          // access completes this edge
  logic              wr;            // write completes
  logic              rd;            // read completes
  logic              mapped;        // index hits a register
  logic [15:0]       rd_data;       // readback mux
  logic              w_chk;         // write to checker control
  logic              freeze_cmd;    // freeze command written
  logic              clear_cmd;     // clear command written
  logic              count_en;      // a byte is counted
  logic [2:0]        rx_thr;        // assembled rx threshold
  logic [2:0]        tx_thr;        // assembled tx threshold
  logic [IRQ_W-1:0]  events;        // event pulses
  logic              byte_wrap;     // byte counter wraps
  logic              byte_hit_max;  // byte counter reaches max in single

  localparam logic [ERR_W-1:0]  ERR_MAX  = '1; // saturation value
  localparam logic [BYTE_W-1:0] BYTE_MAX = '1; // saturation value

  assign idx    = paddr[7:2];
  // the access ends on the edge where ready is already high
  assign done   = psel && penable && pready_q;
  assign wr     = done && pwrite;
  assign rd     = done && !pwrite;
  assign mapped = (idx == IDX_THR_LOW) || (idx == IDX_FIFO_CTRL) || (idx == IDX_NEG_STAT) ||
                  (idx == IDX_CHK_CTRL) || (idx == IDX_CHK_BYTES) || (idx == IDX_IRQ_STAT) ||
                  (idx == IDX_IRQ_MASK);
  assign w_chk      = wr && (idx == IDX_CHK_CTRL);
  // R11 freeze on bit7
  assign freeze_cmd = w_chk && pwdata[B_FREEZE];
  // R12 freeze and clear
  assign clear_cmd  = w_chk && pwdata[B_CLEAR];
  // R17 count only while enabled and not frozen
  assign count_en   = chk_en_q && chk_evt.byte_valid && !frozen_q && !clear_cmd;
  // R04 rx threshold assembly
  assign rx_thr = {fifo_ctrl_q[B_RX_THR_TOP], rx_low_q};
  // R05 tx threshold assembly
  assign tx_thr = {fifo_ctrl_q[B_TX_THR_TOP], tx_low_q};
  assign byte_wrap    = count_en && cnt_mode_q && (byte_cnt_q == BYTE_MAX);
  assign byte_hit_max = count_en && !cnt_mode_q && (byte_cnt_q == BYTE_MAX - 1'b1);

  // event pulses for the interrupt block
  always_comb begin
    events              = '0;
    events[E_SYNC_LOST] = chk_evt.sync_loss && chk_en_q;
    events[E_BYTE_OVF]  = byte_wrap || byte_hit_max;
    events[E_PAGE_RX]   = neg_page_rx;
    events[E_NEG_DONE]  = serial_neg_done && !neg_done_q;
  end

  // readback mux; reserved bits read zero
  always_comb begin
    rd_data = REG_RST;
    unique case (idx)
      IDX_THR_LOW: begin
        rd_data[B_RX_LOW_HI:B_RX_LOW_LO] = rx_low_q;
        rd_data[B_TX_LOW_HI:B_TX_LOW_LO] = tx_low_q;
      end
      IDX_FIFO_CTRL: begin
        rd_data[B_SKIP_EN:B_TX_THR_TOP] = fifo_ctrl_q;
      end
      IDX_NEG_STAT: begin
        // R08 page received status
        rd_data[B_PAGE_RX]  = neg_page_rx;
        // R09 negotiation done status
        rd_data[B_NEG_DONE] = serial_neg_done;
      end
      IDX_CHK_CTRL: begin
        // R10 error count field
        rd_data[B_ERR_HI:B_ERR_LO] = err_cnt_q;
        rd_data[B_SYNC_LOST]       = sync_lost_q;
        // R14 live lock status
        rd_data[B_LOCKED]          = chk_evt.locked;
        rd_data[B_BYTE_OVF]        = byte_ovf_q;
        rd_data[B_CNT_MODE]        = cnt_mode_q;
        rd_data[B_CHK_EN]          = chk_en_q;
      end
      IDX_CHK_BYTES: begin
        // R18 total byte count
        rd_data[BYTE_W-1:0] = byte_cnt_q;
      end
      IDX_IRQ_STAT: begin
        rd_data[IRQ_W-1:0] = irq_stat_q;
      end
      IDX_IRQ_MASK: begin
        rd_data[IRQ_W-1:0] = irq_mask_q;
      end
      default: begin
        rd_data = REG_RST;
      end
    endcase
  end

  // apb handshake: ready one cycle into the access phase
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (ce) begin
      if (psel && penable && !pready_q) begin
        pready_q  <= 1'b1;
        pslverr_q <= !mapped;
        prdata_q  <= {16'h0000, rd_data};
      end else begin
        // drop ready after the completing edge
        pready_q  <= 1'b0;
        pslverr_q <= 1'b0;
      end
    end
  end

  // threshold low bits and fifo control writes
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rx_low_q    <= THR_LOW_RST;
      tx_low_q    <= THR_LOW_RST;
      fifo_ctrl_q <= REG_RST[4:0];
    end else if (ce) begin
      if (wr && (idx == IDX_THR_LOW)) begin
        rx_low_q <= pwdata[B_RX_LOW_HI:B_RX_LOW_LO];
        tx_low_q <= pwdata[B_TX_LOW_HI:B_TX_LOW_LO];
      end
      if (wr && (idx == IDX_FIFO_CTRL)) begin
        fifo_ctrl_q <= pwdata[B_SKIP_EN:B_TX_THR_TOP];
      end
    end
  end

  // fifo path controls, registered so outputs come from flops
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      fifo_ctl_q <= '0;
    end else if (ce) begin
      // R01 async fifo bypass
      fifo_ctl_q.skip_enable  <= fifo_ctrl_q[B_SKIP_EN];
      // R02 rx clock delay only at 10/100
      fifo_ctl_q.rxclk_delay  <= fifo_ctrl_q[B_SKIP_DLY] && speed_10_100;
      // R03 low latency only at 10/100
      fifo_ctl_q.low_latency  <= fifo_ctrl_q[B_LOW_LAT] && speed_10_100;
      fifo_ctl_q.rx_threshold <= rx_thr;
      fifo_ctl_q.tx_threshold <= tx_thr;
      // R06 R07 start gap is threshold plus two, one read cycle per step
      fifo_ctl_q.rx_start_gap <= {1'b0, rx_thr} + THR_GAP_OFS;
      fifo_ctl_q.tx_start_gap <= {1'b0, tx_thr} + THR_GAP_OFS;
    end
  end

  // checker enable, mode and freeze state
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      chk_en_q   <= 1'b0;
      cnt_mode_q <= 1'b0;
      frozen_q   <= 1'b0;
    end else if (ce) begin
      if (w_chk) begin
        // R17 enable bit
        chk_en_q   <= pwdata[B_CHK_EN];
        // R16 mode bit
        cnt_mode_q <= pwdata[B_CNT_MODE];
        // R11 R12 freeze holds until a write with neither command
        frozen_q   <= freeze_cmd || clear_cmd;
      end
    end
  end

  // errored byte counter
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      err_cnt_q <= '0;
    end else if (ce) begin
      if (clear_cmd) begin
        // R12 clear counts
        err_cnt_q <= '0;
      end else if (count_en && chk_evt.byte_error) begin
        // R10 R19 saturate in single mode, wrap in continuous
        if (cnt_mode_q || (err_cnt_q != ERR_MAX)) begin
          err_cnt_q <= err_cnt_q + 1'b1;
        end
      end
    end
  end

  // total byte counter and its overflow flag
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      byte_cnt_q <= '0;
      byte_ovf_q <= 1'b0;
    end else if (ce) begin
      if (clear_cmd) begin
        byte_cnt_q <= '0;
        byte_ovf_q <= 1'b0;
      end else if (count_en) begin
        // R18 R19 saturate in single mode, wrap in continuous
        if (cnt_mode_q || (byte_cnt_q != BYTE_MAX)) begin
          byte_cnt_q <= byte_cnt_q + 1'b1;
        end
        // R15 overflow when max reached or wrapped
        if (byte_wrap || byte_hit_max) begin
          byte_ovf_q <= 1'b1;
        end
      end
    end
  end

  // sync loss latch, cleared by reading the control register
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sync_lost_q <= 1'b0;
    end else if (ce) begin
      // R13 a new loss wins over the read clear
      if (events[E_SYNC_LOST]) begin
        sync_lost_q <= 1'b1;
      end else if (rd && (idx == IDX_CHK_CTRL)) begin
        sync_lost_q <= 1'b0;
      end
    end
  end

  // sticky event status, write one to clear; set beats clear
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      neg_done_q <= 1'b0;
    end else if (ce) begin
      neg_done_q <= serial_neg_done;
      if (wr && (idx == IDX_IRQ_STAT)) begin
        irq_stat_q <= (irq_stat_q & ~pwdata[IRQ_W-1:0]) | events;
      end else begin
        irq_stat_q <= irq_stat_q | events;
      end
      if (wr && (idx == IDX_IRQ_MASK)) begin
        irq_mask_q <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // interrupt level; mask bit one lets the event through
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign fifo_ctl           = fifo_ctl_q;
  assign checker_enable     = chk_en_q;
  assign checker_count_mode = cnt_mode_q;
  assign irq                = irq_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  skip_follow_a: assert property (ce && wr && idx == IDX_FIFO_CTRL ##1 ce |=> // R01
    fifo_ctl_q.skip_enable == $past(pwdata[B_SKIP_EN], 2))
    else $error("bypass output does not follow written bit");
  rxdly_gate_a: assert property (ce && !speed_10_100 |=> !fifo_ctl_q.rxclk_delay) // R02
    else $error("rx clock delay active outside 10/100");
  lowlat_gate_a: assert property (ce && fifo_ctl_q.low_latency |-> $past(speed_10_100)) // R03
    else $error("low latency active outside 10/100");
  // sampled reset in the antecedent: the disable sees the release at once, the flops one edge later
  gap_thr_a: assert property (reset_n && ce |=> fifo_ctl_q.rx_start_gap == {1'b0, $past(rx_thr)} + THR_GAP_OFS) // R07
    else $error("rx start gap not threshold plus two");
  tx_gap_a: assert property (reset_n && ce |=> fifo_ctl_q.tx_start_gap == {1'b0, $past(tx_thr)} + THR_GAP_OFS) // R07
    else $error("tx start gap not threshold plus two");
  err_sat_a: assert property (ce && !cnt_mode_q && err_cnt_q == ERR_MAX && !clear_cmd |=> // R10
    err_cnt_q == ERR_MAX)
    else $error("error count left saturation in single mode");
  byte_sat_a: assert property (ce && !cnt_mode_q && byte_cnt_q == BYTE_MAX && !clear_cmd |=> // R18
    byte_cnt_q == BYTE_MAX)
    else $error("byte count left saturation in single mode");
  freeze_hold_a: assert property (ce && frozen_q && !w_chk |=> $stable(byte_cnt_q) && $stable(err_cnt_q)) // R11
    else $error("counters moved while frozen");
  clear_zero_a: assert property (ce && clear_cmd |=> byte_cnt_q == '0 && err_cnt_q == '0 && frozen_q) // R12
    else $error("clear command did not zero and freeze");
  sync_latch_a: assert property (ce && events[E_SYNC_LOST] |=> sync_lost_q) // R13
    else $error("sync loss not latched");
  // a read of the control register is the only thing allowed to drop the latch
  sync_hold_a: assert property (ce && sync_lost_q && !(rd && idx == IDX_CHK_CTRL) |=> sync_lost_q) // R13
    else $error("sync loss dropped without a read");
  wrap_ovf_a: assert property (ce && byte_wrap |=> byte_ovf_q && byte_cnt_q == '0) // R19
    else $error("wrap did not set overflow");
  irq_level_a: assert property (ce && |(irq_stat_q & irq_mask_q) |=> irq_q)
    else $error("interrupt missing for unmasked event");
  irq_quiet_a: assert property (ce && (irq_stat_q & irq_mask_q) == '0 |=> !irq_q)
    else $error("interrupt raised with no unmasked event");

endmodule

// *** bench/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pmfc_pkg::*;

  logic           core_clk;        // 40 MHz bench clock
  logic           reset_n;         // synchronous reset, low active
  logic           ce;              // clock enable, dropped low for one byte burst
  logic           psel;            // apb select
  logic           penable;         // apb access phase
  logic           pwrite;          // apb direction
  logic [7:0]     paddr;           // apb byte address
  logic [31:0]    pwdata;          // apb write data
  logic [31:0]    prdata;          // apb read data
  logic           pready;          // apb ready
  logic           pslverr;         // apb error
  logic           speed_10_100;    // link speed class
  logic           neg_page_rx;     // page received level
  logic           serial_neg_done; // negotiation finished level
  pmfc_chk_evt_t  chk_evt;         // checker events
  pmfc_fifo_ctl_t fifo_ctl;        // fifo path controls
  logic           checker_enable;  // checker on
  logic           checker_count_mode; // continuous counting
  logic           irq;             // level interrupt
  int             bad_count;       // mismatches seen
  int             n_tests;         // comparisons made

  pmfc_regs u_dut (
    .core_clk           (core_clk),
    .reset_n            (reset_n),
    .ce                 (ce),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .speed_10_100       (speed_10_100),
    .neg_page_rx        (neg_page_rx),
    .serial_neg_done    (serial_neg_done),
    .chk_evt            (chk_evt),
    .fifo_ctl           (fifo_ctl),
    .checker_enable     (checker_enable),
    .checker_count_mode (checker_count_mode),
    .irq                (irq)
  );

  // free running clock, 25 ns period
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // verdict and end of run, shared by the tests and the watchdog
  task automatic conclude();
    if (bad_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // single compare for every kind of result
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    // wait bounded so a dead slave cannot hang the run
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk("pready timeout", 32'h0000_0001, 32'h0000_0000);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [15:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, {idx, 2'b00}, d, rd, er);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [15:0] exp, input string name);
    logic [31:0] v;
    logic        er;
    apb(1'b0, {idx, 2'b00}, 16'h0000, v, er);
    chk(name, {16'h0000, exp}, v);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // n checker bytes, one per cycle, optionally errored
  task automatic bytes(input int n, input logic e);
    repeat (n) begin
      @(posedge core_clk);
      chk_evt.byte_valid <= 1'b1;
      chk_evt.byte_error <= e;
    end
    @(posedge core_clk);
    chk_evt.byte_valid <= 1'b0;
    chk_evt.byte_error <= 1'b0;
    idle(2);
  endtask

  // watchdog sized well above the longest counting run
  initial begin
    #2400000;
    bad_count++;
    conclude();
  end

  initial begin
    logic [31:0] v;
    logic        er;
    bad_count = 0;
    n_tests = 0;
    reset_n = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    speed_10_100 = 1'b0;
    neg_page_rx = 1'b0;
    serial_neg_done = 1'b0;
    chk_evt = '0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    idle(2);
    // default threshold 2 gives pointer lead 4
    chk("fifo_ctl rst", {15'h0000, 3'h0, 3'h2, 3'h2, 4'h4, 4'h4}, fifo_ctl);
    rd(IDX_THR_LOW, 16'h0050, "thr_low rst");
    rd(IDX_FIFO_CTRL, 16'h0000, "fifo ctrl rst");
    rd(IDX_NEG_STAT, 16'h0000, "neg rst");
    rd(IDX_CHK_CTRL, 16'h0000, "chk ctrl rst");
    rd(IDX_CHK_BYTES, 16'h0000, "bytes rst");
    rd(IDX_IRQ_MASK, 16'h0000, "mask rst");
    apb(1'b0, 8'h00, 16'h0000, v, er);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, v);
    // control bits, reserved bits stay zero
    speed_10_100 <= 1'b1;
    wr(IDX_FIFO_CTRL, 16'hFFFF);
    rd(IDX_FIFO_CTRL, 16'h001F, "fifo ctrl rw");
    chk("fifo_ctl all", {15'h0000, 3'h7, 3'h6, 3'h6, 4'h8, 4'h8}, fifo_ctl);
    // threshold steps move the start gap one for one
    wr(IDX_THR_LOW, 16'h0068);
    idle(2);
    chk("fifo_ctl thr", {15'h0000, 3'h7, 3'h7, 3'h5, 4'h9, 4'h7}, fifo_ctl);
    speed_10_100 <= 1'b0;
    wr(IDX_FIFO_CTRL, 16'h0010);
    idle(2);
    chk("fifo_ctl slow", {15'h0000, 3'h4, 3'h3, 3'h1, 4'h5, 4'h3}, fifo_ctl);
    neg_page_rx <= 1'b1;
    serial_neg_done <= 1'b1;
    idle(2);
    rd(IDX_NEG_STAT, 16'h0003, "neg both");
    neg_page_rx <= 1'b0;
    rd(IDX_NEG_STAT, 16'h0001, "neg done");
    rd(IDX_IRQ_STAT, 16'h000C, "irq neg");
    chk("irq masked", 32'h0, irq);
    wr(IDX_IRQ_MASK, 16'h0008);
    idle(2);
    chk("irq on", 32'h1, irq);
    wr(IDX_IRQ_STAT, 16'h0008);
    idle(2);
    chk("irq off", 32'h0, irq);
    rd(IDX_IRQ_STAT, 16'h0004, "irq w1c");
    wr(IDX_IRQ_STAT, 16'h0004);
    chk_evt.locked <= 1'b1;
    wr(IDX_CHK_CTRL, 16'h0001);
    // the write lands on the edge the task returns at; look one edge later
    idle(1);
    chk("chk en", 32'h1, checker_enable);
    bytes(5, 1'b0);
    bytes(2, 1'b1);
    rd(IDX_CHK_CTRL, 16'h0111, "ctrl count");
    rd(IDX_CHK_BYTES, 16'h0007, "bytes count");
    wr(IDX_CHK_CTRL, 16'h0081);
    bytes(3, 1'b1);
    rd(IDX_CHK_BYTES, 16'h0007, "bytes frozen");
    rd(IDX_CHK_CTRL, 16'h0111, "err frozen");
    // clear empties counters and stays frozen
    wr(IDX_CHK_CTRL, 16'h0101);
    bytes(3, 1'b0);
    rd(IDX_CHK_BYTES, 16'h0000, "bytes clear");
    rd(IDX_CHK_CTRL, 16'h0011, "err clear");
    wr(IDX_CHK_CTRL, 16'h0001);
    // sync loss latched until read, live lock
    @(posedge core_clk);
    chk_evt.sync_loss <= 1'b1;
    @(posedge core_clk);
    chk_evt.sync_loss <= 1'b0;
    idle(2);
    rd(IDX_CHK_CTRL, 16'h0031, "sync lost");
    rd(IDX_CHK_CTRL, 16'h0011, "sync read clr");
    chk_evt.locked <= 1'b0;
    rd(IDX_CHK_CTRL, 16'h0001, "unlocked");
    rd(IDX_IRQ_STAT, 16'h0001, "irq sync");
    wr(IDX_IRQ_STAT, 16'h0001);
    bytes(300, 1'b1);
    rd(IDX_CHK_CTRL, 16'h7F81, "err sat");
    rd(IDX_CHK_BYTES, 16'h012C, "bytes 300");
    // clock enable low: bytes offered meanwhile must not count
    ce <= 1'b0;
    bytes(4, 1'b1);
    ce <= 1'b1;
    rd(IDX_CHK_BYTES, 16'h012C, "bytes ce low");
    wr(IDX_CHK_CTRL, 16'h0101);
    wr(IDX_CHK_CTRL, 16'h0003);
    idle(1);
    chk("count mode", 32'h1, checker_count_mode);
    bytes(257, 1'b1);
    rd(IDX_CHK_CTRL, 16'h0083, "err wrap");
    rd(IDX_CHK_BYTES, 16'h0101, "bytes 257");
    // single mode byte count saturates and flags overflow
    wr(IDX_CHK_CTRL, 16'h0103);
    wr(IDX_CHK_CTRL, 16'h0001);
    bytes(65536, 1'b0);
    rd(IDX_CHK_BYTES, 16'hFFFF, "bytes sat");
    rd(IDX_CHK_CTRL, 16'h0005, "overflow");
    rd(IDX_IRQ_STAT, 16'h0002, "irq ovf");
    wr(IDX_IRQ_MASK, 16'h0002);
    idle(2);
    chk("irq ovf on", 32'h1, irq);
    wr(IDX_IRQ_STAT, 16'h0002);
    idle(2);
    chk("irq ovf off", 32'h0, irq);
    // switch the saturated counter to continuous: one byte wraps it
    wr(IDX_CHK_CTRL, 16'h0003);
    bytes(1, 1'b0);
    rd(IDX_CHK_BYTES, 16'h0000, "bytes wrap");
    rd(IDX_IRQ_STAT, 16'h0002, "irq wrap");
    wr(IDX_CHK_CTRL, 16'h0101);
    rd(IDX_CHK_CTRL, 16'h0001, "ovf clear");
    conclude();
  end
endmodule
